// ===== relay_sweep_defs.svh
// constants for the relay sweep search controller
`ifndef RELAY_SWEEP_DEFS_SVH
`define RELAY_SWEEP_DEFS_SVH

`define CLK_PERIOD_NS   20
`define TICK_PERIOD_NS  10000000
`define TICKS_PER_TENTH 32'h0000000a
`define TICK_CNT_W      20
`define SPAN_W          32
`define FRAC_W          17
`define FRAC_ZERO       17'h00000
`define FRAC_ONE        17'h10000
`define DIV_STEPS       5'h11
`define DBL_MAX         4'hf
`define JUDGE_W         10
`define RUN_W           4

`endif

// ===== relay_sweep_pkg.sv
// shared types for the relay sweep search controller
package relay_sweep_pkg;

  // one set of amplifier output parameters
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] amp;
    logic [15:0] phase;
  } param_set_type;

  typedef enum logic [2:0] {st_idle, st_ramp, st_hold, st_judge, st_done} state_type;

  typedef enum logic [1:0] {mode_normal, mode_search, mode_disk} mode_type;

endpackage : relay_sweep_pkg

// ===== frac_divider.sv
// serial divider giving position over span as a 17-bit fraction scaled by 2^16
`timescale 1ns/10ps
`default_nettype none
`include "relay_sweep_defs.svh"

module frac_divider (
  input  wire logic                 mclk,     // system clock
  input  wire logic                 rst,      // synchronous reset
  input  wire logic                 ce,       // clock enable
  input  wire logic [`SPAN_W-1:0]   num,      // position, never above den
  input  wire logic [`SPAN_W-1:0]   den,      // span
  output logic      [`FRAC_W-1:0]   frac      // num/den scaled by 2^16
);

  logic [4:0]         step_ff, nxt_step;
  logic [`SPAN_W:0]   rem_ff, nxt_rem;
  logic [`SPAN_W-1:0] den_ff, nxt_den;
  logic [`FRAC_W-1:0] quo_ff, nxt_quo;
  logic [`FRAC_W-1:0] frac_ff, nxt_frac;
  logic               qbit;

  // restoring division, one quotient bit per cycle, restarts forever
  always_comb begin
    nxt_step = step_ff;
    nxt_rem  = rem_ff;
    nxt_den  = den_ff;
    nxt_quo  = quo_ff;
    nxt_frac = frac_ff;
    qbit     = 1'b0;
    if (step_ff == 5'h00) begin
      nxt_rem  = {1'b0, num};
      nxt_den  = den;
      nxt_quo  = `FRAC_ZERO;
      nxt_step = 5'h01;
    end else begin
      qbit     = (rem_ff >= {1'b0, den_ff}) && (den_ff != '0);
      nxt_rem  = (qbit ? rem_ff - {1'b0, den_ff} : rem_ff) << 1;
      nxt_quo  = {quo_ff[`FRAC_W-2:0], qbit};
      nxt_step = (step_ff == `DIV_STEPS) ? 5'h00 : step_ff + 5'h01;
      if (step_ff == `DIV_STEPS) begin
        nxt_frac = {quo_ff[`FRAC_W-2:0], qbit};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      step_ff <= 5'h00;
      rem_ff  <= '0;
      den_ff  <= '0;
      quo_ff  <= `FRAC_ZERO;
      frac_ff <= `FRAC_ZERO;
    end else if (ce) begin
      step_ff <= nxt_step;
      rem_ff  <= nxt_rem;
      den_ff  <= nxt_den;
      quo_ff  <= nxt_quo;
      frac_ff <= nxt_frac;
    end
  end

  assign frac = frac_ff;

endmodule : frac_divider
`default_nettype wire

// ===== relay_sweep_search_controller.sv
// sweep and search sequencer for the amplifier output of a relay tester
`timescale 1ns/10ps
`default_nettype none
`include "relay_sweep_defs.svh"

module relay_sweep_search_controller #(
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS  // 10 ms tick
) (
  input  wire logic                      mclk,                  // 50 MHz clock
  input  wire logic                      rst,                   // sync reset, high
  input  wire logic                      ce,                    // clock enable
  input  wire relay_sweep_pkg::param_set_type normal_set,       // normal values
  input  wire relay_sweep_pkg::param_set_type fault_set,        // fault values
  input  wire logic [13:0]               sweep_time,            // 0.1 s units, 10..10000
  input  wire logic                      manual_ramp_select,    // 1 manual ramp
  input  wire logic [`SPAN_W-1:0]        manual_elapsed,        // 10 ms units
  input  wire relay_sweep_pkg::mode_type search_mode,           // normal, search, disk
  input  wire logic [`RUN_W-1:0]         ramp_run_count,        // 1..10
  input  wire logic [6:0]                judge_interval,        // 0.1 s units, 1..100
  input  wire logic [6:0]                trip_wait_interval,    // 0.1 s units, 1..100
  input  wire logic                      output_cut_en,         // cut output when done
  input  wire logic                      key_down,              // sweep-down key pulse
  input  wire logic                      key_up,                // sweep-up key pulse
  input  wire logic                      key_stop,              // stop key pulse
  input  wire logic                      start_in,              // external start pulse
  input  wire logic                      trip_in,               // relay trip, high on
  output relay_sweep_pkg::param_set_type amp_out,               // amplifier setpoint
  output logic                           amp_enable,            // amplifier on
  output logic                           ind_down,              // sweep-down lamp
  output logic                           ind_up,                // sweep-up lamp
  output logic                           ind_stop,              // stop lamp
  output logic                           ind_manual,            // manual mark
  output logic                           ind_trip,              // trip lamp
  output logic [`SPAN_W-1:0]             elapsed_time,          // 10 ms units
  output logic [`RUN_W-1:0]             run_index,             // counted runs
  output relay_sweep_pkg::param_set_type operation_value_result,// captured on trip
  output relay_sweep_pkg::param_set_type recovery_value_result, // captured on release
  output logic                           result_valid,          // a value was captured
  output logic                           result_error           // nothing detected
);

  // one parameter: normal plus signed share of the difference
  function automatic logic [15:0] blend_one(input logic [15:0] nv, input logic [15:0] fv,
                                            input logic [`FRAC_W-1:0] fr);
    logic signed [16:0] diff;
    logic signed [34:0] prod;
    diff      = $signed({1'b0, fv}) - $signed({1'b0, nv});
    prod      = diff * $signed({1'b0, fr});
    blend_one = nv + prod[31:16];
  endfunction : blend_one

  relay_sweep_pkg::state_type state_ff, nxt_state;
  logic [`TICK_CNT_W-1:0] tick_cnt_ff, nxt_tick_cnt;
  logic                   tick;
  logic [`SPAN_W-1:0]     pos_ff, nxt_pos, span, base_span;
  logic [3:0]             dbl_ff, nxt_dbl;
  logic                   dir_ff, nxt_dir;          // 1 toward fault
  logic                   op_det_ff, nxt_op_det;    // 1 operation detection
  logic                   trip_q_ff, trip_ref_ff, nxt_trip_ref;
  logic                   disk_wait_ff, nxt_disk_wait;
  logic [`JUDGE_W-1:0]    judge_ff, nxt_judge;
  logic [`RUN_W-1:0]      runs_ff, nxt_runs;
  logic                   amp_en_ff, nxt_amp_en, err_ff, nxt_err, valid_ff, nxt_valid;
  logic                   cap_op, cap_rec, start_cmd, start_fault, trip_rise, trip_fall;
  logic [`FRAC_W-1:0]     frac;
  relay_sweep_pkg::param_set_type out_ff, op_res_ff, rec_res_ff;
  logic                   ind_down_ff, ind_up_ff, ind_stop_ff, ind_man_ff, ind_trip_ff;

  // the doubled span scales the ramp rate; position doubles with it
  assign base_span = 32'(sweep_time) * `TICKS_PER_TENTH;
  assign span      = base_span << dbl_ff;
  assign tick      = (tick_cnt_ff == `TICK_CNT_W'(TICK_CYCLES - 1));
  assign trip_rise = trip_in & ~trip_q_ff;
  assign trip_fall = ~trip_in & trip_q_ff;
  assign start_cmd   = ~manual_ramp_select & (key_down | key_up | start_in);
  assign start_fault = key_down | (start_in & ~key_up & dir_ff);

  frac_divider u_div (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .num  (pos_ff),
    .den  (span),
    .frac (frac)
  );

  // sequencer next state
  always_comb begin
    nxt_state     = state_ff;
    nxt_pos       = pos_ff;
    nxt_dbl       = dbl_ff;
    nxt_dir       = dir_ff;
    nxt_op_det    = op_det_ff;
    nxt_trip_ref  = trip_ref_ff;
    nxt_disk_wait = disk_wait_ff;
    nxt_judge     = judge_ff;
    nxt_runs      = runs_ff;
    nxt_amp_en    = amp_en_ff;
    nxt_err       = err_ff;
    nxt_valid     = valid_ff;
    nxt_tick_cnt  = tick ? '0 : tick_cnt_ff + `TICK_CNT_W'(1);
    cap_op        = 1'b0;
    cap_rec       = 1'b0;
    if (manual_ramp_select) begin
      // position follows the entered time, clamped to one traversal
      nxt_state = relay_sweep_pkg::st_idle;
      nxt_dbl   = 4'h0;
      nxt_pos   = (manual_elapsed > base_span) ? base_span : manual_elapsed;
    end else if (start_cmd && state_ff != relay_sweep_pkg::st_ramp &&
                 state_ff != relay_sweep_pkg::st_judge) begin
      nxt_dir      = start_fault;
      nxt_amp_en   = 1'b1;
      nxt_state    = relay_sweep_pkg::st_ramp;
      nxt_tick_cnt = '0;
      if (search_mode != relay_sweep_pkg::mode_normal) begin
        nxt_op_det = start_fault;
        nxt_dbl    = 4'h0;
        nxt_runs   = '0;
        nxt_err    = 1'b0;
        nxt_valid  = 1'b0;
        nxt_pos    = (dbl_ff == 4'h0) ? pos_ff : (pos_ff >> dbl_ff);
        if (search_mode == relay_sweep_pkg::mode_disk && start_fault) begin
          nxt_pos       = base_span;
          nxt_state     = relay_sweep_pkg::st_judge;
          nxt_disk_wait = 1'b1;
          nxt_judge     = `JUDGE_W'(trip_wait_interval) * `JUDGE_W'(10);
        end
      end
    end else if (state_ff == relay_sweep_pkg::st_ramp) begin
      if (key_stop) begin
        nxt_state = relay_sweep_pkg::st_hold;
      end else if ((dir_ff && trip_rise) || (!dir_ff && trip_fall)) begin
        if (search_mode == relay_sweep_pkg::mode_normal) begin
          nxt_state = relay_sweep_pkg::st_hold;
          cap_op    = dir_ff;
          cap_rec   = ~dir_ff;
          nxt_valid = 1'b1;
        end else begin
          nxt_state    = relay_sweep_pkg::st_judge;
          nxt_trip_ref = trip_in;
          nxt_judge    = `JUDGE_W'(judge_interval) * `JUDGE_W'(10);
          if (dir_ff == op_det_ff) nxt_runs = runs_ff + `RUN_W'(1);
        end
      end else if (dir_ff ? (pos_ff >= span) : (pos_ff == '0)) begin
        nxt_state = relay_sweep_pkg::st_hold;
        if (search_mode != relay_sweep_pkg::mode_normal) begin
          nxt_state  = relay_sweep_pkg::st_done;
          nxt_err    = 1'b1;
          nxt_amp_en = ~output_cut_en;
        end
      end else if (tick) begin
        nxt_pos = dir_ff ? pos_ff + 32'h1 : pos_ff - 32'h1;
      end
    end else if (state_ff == relay_sweep_pkg::st_judge) begin
      if (tick && judge_ff != '0) begin
        nxt_judge = judge_ff - `JUDGE_W'(1);
      end else if (judge_ff == '0) begin
        nxt_state     = relay_sweep_pkg::st_ramp;
        nxt_disk_wait = 1'b0;
        if (disk_wait_ff) begin
          // relay must be tripped at fault before the release search
          nxt_dir = 1'b0;
          if (!trip_in) begin
            nxt_state  = relay_sweep_pkg::st_done;
            nxt_err    = 1'b1;
            nxt_amp_en = ~output_cut_en;
          end
        end else if (runs_ff >= ramp_run_count) begin
          nxt_state  = relay_sweep_pkg::st_done;
          cap_op     = op_det_ff;
          cap_rec    = ~op_det_ff;
          nxt_valid  = 1'b1;
          nxt_amp_en = ~output_cut_en;
        end else begin
          nxt_dir = (trip_in == trip_ref_ff) ? ~dir_ff : dir_ff;
          if (dbl_ff != `DBL_MAX) begin
            nxt_dbl = dbl_ff + 4'h1;
            nxt_pos = pos_ff << 1;
          end
        end
      end
    end
  end

  // sequencer registers and captured results
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff     <= relay_sweep_pkg::st_idle;
      tick_cnt_ff  <= '0;
      pos_ff       <= '0;
      dbl_ff       <= 4'h0;
      dir_ff       <= 1'b1;
      op_det_ff    <= 1'b1;
      trip_q_ff    <= 1'b0;
      trip_ref_ff  <= 1'b0;
      disk_wait_ff <= 1'b0;
      judge_ff     <= '0;
      runs_ff      <= '0;
      amp_en_ff    <= 1'b1;
      err_ff       <= 1'b0;
      valid_ff     <= 1'b0;
      op_res_ff    <= '0;
      rec_res_ff   <= '0;
    end else if (ce) begin
      state_ff     <= nxt_state;
      tick_cnt_ff  <= nxt_tick_cnt;
      pos_ff       <= nxt_pos;
      dbl_ff       <= nxt_dbl;
      dir_ff       <= nxt_dir;
      op_det_ff    <= nxt_op_det;
      trip_q_ff    <= trip_in;
      trip_ref_ff  <= nxt_trip_ref;
      disk_wait_ff <= nxt_disk_wait;
      judge_ff     <= nxt_judge;
      runs_ff      <= nxt_runs;
      amp_en_ff    <= nxt_amp_en;
      err_ff       <= nxt_err;
      valid_ff     <= nxt_valid;
      if (cap_op) op_res_ff <= out_ff;
      if (cap_rec) rec_res_ff <= out_ff;
    end
  end

  // output blend; equal normal and fault give zero difference, so no motion
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_ff      <= '0;
      ind_down_ff <= 1'b0;
      ind_up_ff   <= 1'b0;
      ind_stop_ff <= 1'b0;
      ind_man_ff  <= 1'b0;
      ind_trip_ff <= 1'b0;
    end else if (ce) begin
      out_ff.freq  <= blend_one(normal_set.freq, fault_set.freq, frac);
      out_ff.amp   <= blend_one(normal_set.amp, fault_set.amp, frac);
      out_ff.phase <= blend_one(normal_set.phase, fault_set.phase, frac);
      ind_down_ff  <= (nxt_state == relay_sweep_pkg::st_ramp) && nxt_dir;
      ind_up_ff    <= (nxt_state == relay_sweep_pkg::st_ramp) && !nxt_dir;
      ind_stop_ff  <= (nxt_state == relay_sweep_pkg::st_hold) ||
                      (nxt_state == relay_sweep_pkg::st_done);
      ind_man_ff   <= manual_ramp_select;
      ind_trip_ff  <= trip_in;
    end
  end

  assign amp_out                = out_ff;
  assign amp_enable             = amp_en_ff;
  assign ind_down               = ind_down_ff;
  assign ind_up                 = ind_up_ff;
  assign ind_stop               = ind_stop_ff;
  assign ind_manual             = ind_man_ff;
  assign ind_trip               = ind_trip_ff;
  assign elapsed_time           = pos_ff;
  assign run_index              = runs_ff;
  assign operation_value_result = op_res_ff;
  assign recovery_value_result  = rec_res_ff;
  assign result_valid           = valid_ff;
  assign result_error           = err_ff;

  // checks on the sequencer
  chk_stop_holds_pos: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == relay_sweep_pkg::st_hold && !start_cmd && !manual_ramp_select) |=> $stable(pos_ff))
    else $error("position moved while stopped");
  chk_trip_stops_op: assert property (@(posedge mclk) disable iff (rst)
    (ce && state_ff == relay_sweep_pkg::st_ramp && dir_ff && trip_rise && !key_stop &&
     !manual_ramp_select && search_mode == relay_sweep_pkg::mode_normal)
    |=> (state_ff == relay_sweep_pkg::st_hold && op_res_ff == $past(out_ff)))
    else $error("trip did not stop and capture operation value");
  chk_manual_no_ramp: assert property (@(posedge mclk) disable iff (rst)
    (ce && manual_ramp_select) |=> state_ff == relay_sweep_pkg::st_idle)
    else $error("manual ramp left idle");
  chk_end_holds: assert property (@(posedge mclk) disable iff (rst)
    (ce && state_ff == relay_sweep_pkg::st_ramp && dir_ff && pos_ff >= span && !trip_rise &&
     !key_stop && !manual_ramp_select && search_mode == relay_sweep_pkg::mode_normal)
    |=> state_ff == relay_sweep_pkg::st_hold ##1 pos_ff == $past(pos_ff, 2))
    else $error("end of ramp not held");
  chk_resume_doubles: assert property (@(posedge mclk) disable iff (rst)
    (ce && state_ff == relay_sweep_pkg::st_judge && judge_ff == '0 && !disk_wait_ff &&
     !manual_ramp_select && runs_ff < ramp_run_count && dbl_ff != `DBL_MAX)
    |=> (dbl_ff == $past(dbl_ff) + 4'h1 && pos_ff == $past(pos_ff) << 1))
    else $error("resume did not double sweep time");
  chk_judge_reverse: assert property (@(posedge mclk) disable iff (rst)
    (ce && state_ff == relay_sweep_pkg::st_judge && judge_ff == '0 && !disk_wait_ff &&
     !manual_ramp_select && runs_ff < ramp_run_count)
    |=> dir_ff == ($past(trip_in) == $past(trip_ref_ff) ? !$past(dir_ff) : $past(dir_ff)))
    else $error("wrong direction after judge");
  chk_output_cut: assert property (@(posedge mclk) disable iff (rst)
    (ce && state_ff == relay_sweep_pkg::st_judge && nxt_state == relay_sweep_pkg::st_done &&
     nxt_valid && output_cut_en) |=> !amp_enable ##1 ind_stop)
    else $error("output not cut at completion");
  chk_blend_normal: assert property (@(posedge mclk) disable iff (rst)
    (ce && frac == `FRAC_ZERO) |=> amp_out == $past(normal_set))
    else $error("zero fraction not normal value");
  chk_blend_fault: assert property (@(posedge mclk) disable iff (rst)
    (ce && frac == `FRAC_ONE) |=> amp_out == $past(fault_set))
    else $error("full fraction not fault value");

  cov_op_search_done: cover property (@(posedge mclk) disable iff (rst)
    state_ff == relay_sweep_pkg::st_done && valid_ff && op_det_ff);
  cov_chatter_resume: cover property (@(posedge mclk) disable iff (rst)
    state_ff == relay_sweep_pkg::st_judge ##1 state_ff == relay_sweep_pkg::st_ramp && dbl_ff == 4'h2);
  cov_disk_release: cover property (@(posedge mclk) disable iff (rst)
    disk_wait_ff ##1 (state_ff == relay_sweep_pkg::st_ramp && !dir_ff));

endmodule : relay_sweep_search_controller
`default_nettype wire

// ===== relay_model.sv
// behavioural protective relay driving the trip input
`timescale 1ns/10ps
`default_nettype none
module relay_model (
  input  wire logic        mclk,    // system clock
  input  wire logic        rst,     // sync reset
  input  wire logic [15:0] level,   // applied amplitude
  input  wire logic [15:0] op_lvl,  // pick-up level
  input  wire logic [15:0] rel_lvl, // drop-off level
  input  wire logic [4:0]  lag,     // response delay, cycles
  output logic             trip_in  // contact, high operated
);
  logic       want;
  logic       nxt_trip;
  logic       trip_ff;
  logic [4:0] nxt_cnt;
  logic [4:0] cnt_ff;
  // hysteresis stops chatter; unknown setpoint before first blend is ignored
  always_comb begin
    want = (level >= op_lvl) | (trip_ff & (level > rel_lvl));
    if (^level === 1'bx) want = trip_ff;
    nxt_cnt  = (want == trip_ff) ? 5'h00 : cnt_ff + 5'h01;
    nxt_trip = (want != trip_ff && cnt_ff >= lag) ? want : trip_ff;
  end
  // registered contact, a slow relay answers lag cycles late
  always_ff @(posedge mclk) begin
    trip_ff <= rst ? 1'b0 : nxt_trip;
    cnt_ff  <= rst ? 5'h00 : nxt_cnt;
  end
  assign trip_in = trip_ff;
endmodule : relay_model
`default_nettype wire

// ===== relay_sweep_search_controller_tb_top.sv
// self-checking bench for the relay sweep search controller
`timescale 1ns/10ps
`default_nettype none
module relay_sweep_search_controller_tb_top;
  localparam logic [47:0] NRM = {16'h1388, 16'h0000, 16'h0064};
  localparam logic [47:0] FLT = {16'h1388, 16'h03e8, 16'h00c8};
  localparam logic [47:0] MID = {16'h1388, 16'h01f4, 16'h0096};
  localparam logic [47:0] QTR = {16'h1388, 16'h00fa, 16'h007d};
  logic mclk, rst, man_sel, cut, trip_in, key_down, key_up, key_stop, start_in;
  logic ind_down, ind_up, ind_stop, ind_manual, ind_trip, amp_enable;
  logic result_valid, result_error;
  logic [31:0] man_el, elapsed_time;
  logic [3:0]  runs, run_index;
  logic [6:0]  judge;
  logic [15:0] op_lvl, rel_lvl;
  logic [4:0]  lag;
  logic [47:0] hold;
  logic [50:0] nt;
  logic [50:0] exp_q[$];
  relay_sweep_pkg::mode_type      mode;
  relay_sweep_pkg::param_set_type amp_out, op_res, rec_res;
  int err_count, num_checks, cycles;

  relay_sweep_search_controller #(.TICK_CYCLES(40)) u_dut (
    .mclk(mclk), .rst(rst), .ce(1'b1), .normal_set(NRM), .fault_set(FLT),
    .sweep_time(14'h000a), .manual_ramp_select(man_sel), .manual_elapsed(man_el),
    .search_mode(mode), .ramp_run_count(runs), .judge_interval(judge),
    .trip_wait_interval(7'h01), .output_cut_en(cut), .key_down(key_down),
    .key_up(key_up), .key_stop(key_stop), .start_in(start_in), .trip_in(trip_in),
    .amp_out(amp_out), .amp_enable(amp_enable), .ind_down(ind_down), .ind_up(ind_up),
    .ind_stop(ind_stop), .ind_manual(ind_manual), .ind_trip(ind_trip),
    .elapsed_time(elapsed_time), .run_index(run_index),
    .operation_value_result(op_res), .recovery_value_result(rec_res),
    .result_valid(result_valid), .result_error(result_error));

  relay_model u_relay (.mclk(mclk), .rst(rst), .level(amp_out.amp), .op_lvl(op_lvl),
    .rel_lvl(rel_lvl), .lag(lag), .trip_in(trip_in));

  // clock and hang guard
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 50000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] expv);
    num_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  // observed value picked by a selector code
  function automatic logic [47:0] obs(input logic [2:0] s);
    case (s)
      3'h0: obs = amp_out;
      3'h1: obs = op_res;
      3'h2: obs = rec_res;
      3'h3: obs = {45'h0, ind_down, ind_up, ind_stop};
      3'h4: obs = {43'h0, ind_manual, ind_trip, amp_enable, result_valid, result_error};
      3'h5: obs = {47'h0, result_error};
      3'h6: obs = {16'h0, elapsed_time};
      default: obs = {44'h0, run_index};
    endcase
  endfunction : obs

  task automatic note(input logic [2:0] s, input logic [47:0] v);
    exp_q.push_back({s, v});
  endtask : note

  // every queued note is compared, oldest first, once outputs have settled
  always @(negedge mclk) begin
    while (exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      check(obs(nt[50:48]), nt[47:0]);
    end
  end

  // one-cycle key pulse: bits are down, up, stop, start
  task automatic pulse(input logic [3:0] k);
    @(posedge mclk);
    {key_down, key_up, key_stop, start_in} <= k;
    @(posedge mclk);
    {key_down, key_up, key_stop, start_in} <= 4'h0;
  endtask : pulse

  task automatic wait_stop();
    int n;
    n = 0;
    @(posedge mclk);
    while (ind_stop !== 1'b1 && n < 12000) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_stop

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  initial begin
    mclk = 0; rst = 1; man_sel = 0; man_el = 0; mode = relay_sweep_pkg::mode_normal;
    runs = 4'h1; judge = 7'h01; op_lvl = 16'h01f4; rel_lvl = 16'h00fa;
    {key_down, key_up, key_stop, start_in} = 4'h0;
    void'($urandom(14160));
    cut = 1'($urandom());
    lag = 5'($urandom_range(0, 2)); // a slower answer lets a fast test tick pass the trip point
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (30) @(posedge mclk);
    note(3'h0, NRM);
    note(3'h4, 48'h04);
    $display("reset test done");
    // manual ramp at half the span, commands refused
    man_sel <= 1'b1;
    man_el <= 32'h32;
    repeat (60) @(posedge mclk);
    note(3'h0, MID);
    pulse(4'h8);
    pulse(4'h1);
    note(3'h3, 48'h0);
    note(3'h4, 48'h1c);
    // back to normal so the relay is released before the down ramp starts
    man_el <= 32'h0;
    repeat (60) @(posedge mclk);
    note(3'h4, 48'h14);
    man_sel <= 1'b0;
    repeat (60) @(posedge mclk);
    $display("manual test done");
    // down ramp, stop, resume, trip capture
    pulse(4'h8);
    note(3'h3, 48'h4);
    repeat (400) @(posedge mclk);
    pulse(4'h2);
    note(3'h3, 48'h1);
    repeat (40) @(posedge mclk);
    hold = amp_out;
    repeat (200) @(posedge mclk);
    note(3'h0, hold);
    pulse(4'h1);
    note(3'h3, 48'h4);
    wait_stop();
    note(3'h1, MID);
    note(3'h3, 48'h1);
    pulse(4'h4);
    note(3'h3, 48'h2);
    wait_stop();
    note(3'h2, QTR);
    $display("normal sweep test done");
    // no trip: both ends reached and held
    op_lvl <= 16'hffff;
    rel_lvl <= 16'h0000;
    pulse(4'h8);
    wait_stop();
    repeat (40) @(posedge mclk);
    note(3'h0, FLT);
    note(3'h6, 48'h64);
    pulse(4'h4);
    wait_stop();
    repeat (40) @(posedge mclk);
    note(3'h0, NRM);
    $display("end value test done");
    // search: two counted runs with two reversals, then a search that never trips
    mode <= relay_sweep_pkg::mode_search;
    runs <= 4'h2;
    op_lvl <= 16'h01f4;
    rel_lvl <= 16'h00fa;
    pulse(4'h8);
    wait_stop();
    note(3'h4, {43'h0, 2'b01, ~cut, 2'b10});
    note(3'h1, MID);
    note(3'h7, 48'h2);
    op_lvl <= 16'hffff;
    rel_lvl <= 16'h0000;
    pulse(4'h8);
    wait_stop();
    note(3'h5, 48'h1);
    // disk variant: jump to fault, release search up, one counted run down
    mode <= relay_sweep_pkg::mode_disk;
    runs <= 4'h1;
    op_lvl <= 16'h01f4;
    rel_lvl <= 16'h00fa;
    pulse(4'h8);
    repeat (60) @(posedge mclk);
    note(3'h0, FLT);
    wait_stop();
    note(3'h4, {43'h0, 2'b01, ~cut, 2'b10});
    note(3'h7, 48'h1);
    $display("search test done");
    repeat (2) @(posedge mclk);
    end_of_test();
  end
endmodule : relay_sweep_search_controller_tb_top
`default_nettype wire
